// ==== psc_defines.svh ====
/*
 * Constants for the pipelined burst SRAM cycle decoder: widths, lane masks,
 * clock rate and sleep timing counts.
 * Assumes it is included by bare name from the design modules.
 */
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

`define PSC_ADDR_W        15
`define PSC_BURST_W       2
`define PSC_LANES         4
`define PSC_LANE_DATA_W   8
`define PSC_DATA_W        32
`define PSC_PARITY_W      4
`define PSC_WORD_W        36
`define PSC_LANES_ALL     4'hF
`define PSC_LANES_NONE    4'h0
`define PSC_CLK_PERIOD_NS 40
`define PSC_SLEEP_TCYC    2
`define PSC_SLEEP_CYCLES  2'h2
`define PSC_BURST_ONE     2'h1
`define PSC_BURST_ZERO    2'h0

`endif

// ==== psc_pkg.sv ====
/*
 * Types for the pipelined burst SRAM cycle decoder: access mode and
 * address source.
 * Assumes psc_defines.svh is on the include path.
 */
package psc_pkg;

    // Access mode held between cycles; Gray along idle, read, write, sleep
    typedef enum logic [1:0]
    {
        PSC_IDLE  = 2'b00,
        PSC_READ  = 2'b01,
        PSC_WRITE = 2'b11,
        PSC_SLEEP = 2'b10
    } psc_mode_e;

    // Which address the array sees in the decided cycle
    typedef enum logic [1:0]
    {
        PSC_ADDR_NONE = 2'b00,
        PSC_ADDR_EXT  = 2'b01,
        PSC_ADDR_NEXT = 2'b11,
        PSC_ADDR_CUR  = 2'b10
    } psc_addr_sel_e;

endpackage : psc_pkg

// ==== psc_burst_if.sv ====
/*
 * Carrier between the cycle decoder and its burst counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface psc_burst_if;
    logic       load;     // Seed the counter from the external address
    logic [1:0] seed;     // Two lowest external address bits
    logic       step;     // Advance to the next burst address
    logic       linear;   // High for linear order, low for interleaved
    logic [1:0] curLow;   // Current burst address bits
    logic [1:0] nextLow;  // Address bits after one more step

    modport ctrl (output load, output seed, output step, output linear, input curLow, input nextLow);
    modport cnt  (input load, input seed, input step, input linear, output curLow, output nextLow);
endinterface : psc_burst_if

// ==== psc_burst_counter.sv ====
/*
 * Two-bit wraparound burst counter with interleaved or linear order.
 * Assumes load and step never come together; load wins if they do.
 */
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_burst_counter
    import psc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    psc_burst_if.cnt  bus
);

    logic [1:0] seed_q;   // Start address bits
    logic [1:0] count_q;  // Steps taken since the start
    logic [1:0] countInc; // Count after one more step

    // Interleaved order flips bits of the start, linear order adds to it
    function automatic logic [1:0] burstAddr(input logic [1:0] seed, input logic [1:0] count,
                                             input logic linear);
        burstAddr = linear ? 2'(seed + count) : (seed ^ count);
    endfunction : burstAddr

    assign countInc    = 2'(count_q + `PSC_BURST_ONE);
    assign bus.curLow  = burstAddr(seed_q, count_q, bus.linear);
    assign bus.nextLow = burstAddr(seed_q, countInc, bus.linear);

    // Seed on a new access, step on each advance; wraps after four
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seed_q  <= `PSC_BURST_ZERO;
            count_q <= `PSC_BURST_ZERO;
        end
        else if (bus.load)
        begin
            seed_q  <= bus.seed;
            count_q <= `PSC_BURST_ZERO;
        end
        else if (bus.step)
        begin
            count_q <= countInc;
        end
    end

endmodule : psc_burst_counter

// ==== psc_sram_decode.sv ====
/*
 * Cycle decoder and data-pin control of a 32K x 36 pipelined burst SRAM.
 * Decides each edge whether the next cycle is unselected, begin, continue or
 * suspend read or write, or sleep; drives the array port and the data pins.
 * Assumes the bus master runs on ref_clk, so its synchronous pins need no
 * synchroniser; the sleep and burst order pins are asynchronous and are
 * synchronised. The memory array sits outside and reads combinationally.
 */
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "psc_defines.svh"
// Summary of operation
// - Deselected strobe cycle floats pins, no address
// - Full select with strobe begins external read or write
// - Processor strobe starts read at full select, ignores writes
// - Writes only after processor strobe or controller
// - No strobe, advance low, read: next address
// - No strobe, advance high, read: repeat current
// - Write after processor read uses current address
// - Write burst continues at next address
// - Suspended write burst keeps current address
// - Write request from global or byte enables
// - All write enables high means read
// - Write selected lanes, global writes all four
// - Data pins follow cycle and asynchronous enable
// - Output enable masked during write cycles
// - Read floats when enable high or deselected
// - Read drives all bits when enable low
// - Advance low steps the wraparound burst counter
// - Order select high gives interleaved sequence
// - Order select low gives linear sequence
// - Sleep entry takes two cycles, exit four
module psc_sram_decode
    import psc_pkg::*;
#(
    parameter int ADDR_W = `PSC_ADDR_W,   // Word address width
    parameter int LANES  = `PSC_LANES     // Byte lanes per word
)
(
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic [ADDR_W-1:0]        addr,
    input  wire logic [`PSC_DATA_W-1:0]   dataIn,
    input  wire logic [`PSC_PARITY_W-1:0] parityIn,
    output logic      [`PSC_DATA_W-1:0]   dataOut,
    output logic      [`PSC_PARITY_W-1:0] parityOut,
    output logic                          dataOe,
    input  wire logic                     primary_chip_enable_n,
    input  wire logic                     depth_enable_high,
    input  wire logic                     depth_enable_low_n,
    input  wire logic                     processor_addr_strobe_n,
    input  wire logic                     controller_addr_strobe_n,
    input  wire logic                     burst_advance_n,
    input  wire logic                     global_write_n,
    input  wire logic                     byte_write_enable_n,
    input  wire logic [LANES-1:0]         byte_lane_write_n,
    input  wire logic                     output_enable_n,
    input  wire logic                     sleep_request,
    input  wire logic                     burstOrderSel,
    output logic      [ADDR_W-1:0]        arrayAddr,
    output logic                          arrayRead,
    output logic      [LANES-1:0]         arrayLaneWrite,
    output logic      [`PSC_WORD_W-1:0]   arrayWriteData,
    input  wire logic [`PSC_WORD_W-1:0]   arrayReadData,
    output logic                          sleepActive
);

    // Sleep recovery hold time in nanoseconds
    localparam int SLEEP_NS = `PSC_SLEEP_TCYC * `PSC_CLK_PERIOD_NS;

    // Synchronisers for the asynchronous pins
    logic sleepMeta_q;            // First stage, read only by the second
    logic sleepSync_q;            // Sleep level in the clock domain
    logic orderMeta_q;            // First stage of the order select
    logic orderSync_q;            // High selects interleaved order

    // Sleep and access state
    logic [1:0]    sleepHold_d;   // Cycles of sleep still to keep
    logic [1:0]    sleepHold_q;
    psc_mode_e     mode_d;        // Access kind decided for this cycle
    psc_mode_e     mode_q;
    psc_addr_sel_e addrSel;       // Address source of the decided cycle

    // Array port and output stage registers
    logic [ADDR_W-1:0]        arrayAddr_d;
    logic [ADDR_W-1:0]        arrayAddr_q;
    logic [ADDR_W-1:2]        base_q;        // Upper address bits of the burst
    logic                     arrayRead_d;
    logic                     arrayRead_q;
    logic [LANES-1:0]         laneWrite_d;
    logic [LANES-1:0]         laneWrite_q;
    logic [`PSC_WORD_W-1:0]   writeData_q;
    logic [`PSC_DATA_W-1:0]   dataOut_q;
    logic [`PSC_PARITY_W-1:0] parityOut_q;
    logic                     outValid_d;    // Output register holds read data
    logic                     outValid_q;
    logic                     sleepActive_q;

    // Decoded controls
    logic       sleeping;       // Sleep level or recovery in progress
    logic       fullSelect;     // All three chip enables active
    logic       anyStrobe;      // Either address strobe low
    logic       procStart;      // Processor strobe accepted
    logic       ctrlStart;      // Controller strobe accepted
    logic       unselected;     // Controller strobe, or processor strobe with primary enable low, while not fully selected
    logic       noStrobe;       // No new strobe accepted
    logic       burstOpen;      // An access is in progress to continue
    logic       writeReq;       // Write requested by the enables
    logic [LANES-1:0] laneMask; // Lanes a write would update
    logic       advance;        // Burst advance requested

    psc_burst_if burst ();

    psc_burst_counter u_burst_counter
    (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .bus     (burst.cnt)
    );

    // Two-flop synchronisers; order select resets high as a floating pin does
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleepMeta_q <= 1'b0;
            sleepSync_q <= 1'b0;
            orderMeta_q <= 1'b1;
            orderSync_q <= 1'b1;
        end
        else
        begin
            sleepMeta_q <= sleep_request;
            sleepSync_q <= sleepMeta_q;
            orderMeta_q <= burstOrderSel;
            orderSync_q <= orderMeta_q;
        end
    end

    // The two synchroniser stages make up the entry delay; the hold counter
    // keeps the decoder asleep for the recovery after release
    assign sleepHold_d = sleepSync_q ? `PSC_SLEEP_CYCLES
                       : (sleepHold_q != `PSC_BURST_ZERO) ? 2'(sleepHold_q - `PSC_BURST_ONE)
                       : `PSC_BURST_ZERO;
    assign sleeping    = sleepSync_q | (sleepHold_q != `PSC_BURST_ZERO);

    // Write request and lane selection
    assign writeReq = ~global_write_n
                    | (~byte_write_enable_n & ~(&byte_lane_write_n));
    assign laneMask = ~global_write_n ? `PSC_LANES_ALL
                    : ~byte_write_enable_n ? ~byte_lane_write_n
                    : `PSC_LANES_NONE;

    // Chip select and strobe decode
    assign fullSelect = ~primary_chip_enable_n & depth_enable_high & ~depth_enable_low_n;
    assign anyStrobe  = ~processor_addr_strobe_n | ~controller_addr_strobe_n;
    // Primary enable high masks the processor strobe but not the controller one
    assign unselected = (primary_chip_enable_n & ~controller_addr_strobe_n)
                      | (~primary_chip_enable_n & ~fullSelect & anyStrobe);
    assign procStart  = fullSelect & ~processor_addr_strobe_n;
    assign ctrlStart  = fullSelect & processor_addr_strobe_n & ~controller_addr_strobe_n;
    assign noStrobe   = ~unselected & ~procStart & ~ctrlStart;
    assign burstOpen  = (mode_q == PSC_READ) | (mode_q == PSC_WRITE);
    assign advance    = ~burst_advance_n;

    // Cycle decision; sleep overrides every other control
    always_comb
    begin
        mode_d  = PSC_IDLE;
        addrSel = PSC_ADDR_NONE;
        if (sleeping)
        begin
            mode_d = PSC_SLEEP;
        end
        else if (unselected)
        begin
            mode_d = PSC_IDLE;
        end
        else if (procStart)
        begin
            // Write enables are ignored in this cycle
            mode_d  = PSC_READ;
            addrSel = PSC_ADDR_EXT;
        end
        else if (ctrlStart)
        begin
            // Controller strobe writes in its own cycle
            mode_d  = writeReq ? PSC_WRITE : PSC_READ;
            addrSel = PSC_ADDR_EXT;
        end
        else if (noStrobe && burstOpen)
        begin
            // Continue or suspend; a write here follows an earlier access
            mode_d  = writeReq ? PSC_WRITE : PSC_READ;
            addrSel = advance ? PSC_ADDR_NEXT : PSC_ADDR_CUR;
        end
        else
        begin
            // No access open: nothing to continue
            mode_d = PSC_IDLE;
        end
    end

    // Burst counter control
    assign burst.load   = (addrSel == PSC_ADDR_EXT);
    assign burst.seed   = addr[1:0];
    assign burst.step   = (addrSel == PSC_ADDR_NEXT);
    assign burst.linear = ~orderSync_q;

    // Array address and strobes for the decided cycle
    assign arrayAddr_d = (addrSel == PSC_ADDR_EXT)  ? addr
                       : (addrSel == PSC_ADDR_NEXT) ? {base_q, burst.nextLow}
                       : (addrSel == PSC_ADDR_CUR)  ? {base_q, burst.curLow}
                       : arrayAddr_q;
    assign arrayRead_d = (mode_d == PSC_READ);
    assign laneWrite_d = (mode_d == PSC_WRITE) ? laneMask : `PSC_LANES_NONE;

    // Read data is shown only while the decided cycle is still a read, so a
    // write, a deselect or sleep floats the pins at once
    assign outValid_d = arrayRead_q & (mode_d == PSC_READ);

    // Mode and sleep state
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q        <= PSC_IDLE;
            sleepHold_q   <= `PSC_BURST_ZERO;
            sleepActive_q <= 1'b0;
        end
        else
        begin
            mode_q        <= mode_d;
            sleepHold_q   <= sleepHold_d;
            sleepActive_q <= sleeping;
        end
    end

    // Array port registers; write data taken at the write edge
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arrayAddr_q <= '0;
            base_q      <= '0;
            arrayRead_q <= 1'b0;
            laneWrite_q <= `PSC_LANES_NONE;
            writeData_q <= '0;
        end
        else
        begin
            arrayAddr_q <= arrayAddr_d;
            arrayRead_q <= arrayRead_d;
            laneWrite_q <= laneWrite_d;
            if (addrSel == PSC_ADDR_EXT)
            begin
                base_q <= addr[ADDR_W-1:2];
            end
            if (mode_d == PSC_WRITE)
            begin
                writeData_q <= {parityIn, dataIn};
            end
        end
    end

    // Pipelined output register, loaded one edge after the read address
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dataOut_q   <= '0;
            parityOut_q <= '0;
            outValid_q  <= 1'b0;
        end
        else
        begin
            outValid_q <= outValid_d;
            if (arrayRead_q)
            begin
                dataOut_q   <= arrayReadData[`PSC_DATA_W-1:0];
                parityOut_q <= arrayReadData[`PSC_WORD_W-1:`PSC_DATA_W];
            end
        end
    end

    // Output enable is never sampled, so the pin enable has to be a gate;
    // the write mode term keeps the drivers off even if the master is late
    // raising output enable before a write
    assign dataOe = outValid_q & ~output_enable_n & (mode_q != PSC_WRITE);

    assign dataOut        = dataOut_q;
    assign parityOut      = parityOut_q;
    assign arrayAddr      = arrayAddr_q;
    assign arrayRead      = arrayRead_q;
    assign arrayLaneWrite = laneWrite_q;
    assign arrayWriteData = writeData_q;
    assign sleepActive    = sleepActive_q;

endmodule : psc_sram_decode

// ==== psc_sram_decode_sva.sv ====
/* Checker for psc_sram_decode: cycle decode, burst order and pin float.
   Assumes only the top ports; sleep is taken as quiet after four low samples. */
`timescale 1ns/1ps
module psc_sram_decode_sva
    import psc_pkg::*;
#(
    parameter int ADDR_W = 15,   // Word address width
    parameter int LANES  = 4     // Byte lanes
)
(
    input wire logic              ref_clk, rst_n, dataOe, sleepActive, arrayRead,
    input wire logic              primary_chip_enable_n, depth_enable_high, depth_enable_low_n,
    input wire logic              processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    input wire logic              global_write_n, byte_write_enable_n, output_enable_n,
    input wire logic              sleep_request, burstOrderSel,
    input wire logic [ADDR_W-1:0] addr, arrayAddr,
    input wire logic [31:0]       dataIn,
    input wire logic [3:0]        parityIn,
    input wire logic [LANES-1:0]  arrayLaneWrite,
    input wire logic [35:0]       arrayWriteData
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // All three enables active
    wire logic fullSel = !primary_chip_enable_n && depth_enable_high && !depth_enable_low_n;
    // No strobe taken this edge
    wire logic noStb = processor_addr_strobe_n && controller_addr_strobe_n;
    // Sleep synchroniser needs history, so require a quiet stretch first
    sequence awake_s;
        (!sleep_request)[*4] ##0 !sleepActive;
    endsequence
    sequence procRd_s;
        awake_s ##0 fullSel && !processor_addr_strobe_n;
    endsequence
    sequence suspRd_s;
        awake_s ##0 arrayRead && noStb && burst_advance_n && global_write_n && byte_write_enable_n;
    endsequence
    proc_read_a: assert property (procRd_s |=> arrayRead && arrayLaneWrite == 4'h0 && arrayAddr == $past(addr))
        else $error("processor strobe cycle not a plain read");
    ctrl_write_a: assert property (awake_s ##0 fullSel && processor_addr_strobe_n && !controller_addr_strobe_n
        && !global_write_n |=> arrayLaneWrite == 4'hF && arrayWriteData == $past({parityIn, dataIn}))
        else $error("controller global write wrong");
    deselect_a: assert property (awake_s ##0 primary_chip_enable_n && !controller_addr_strobe_n
        |=> !arrayRead && arrayLaneWrite == 4'h0) else $error("unselected cycle made an access");
    sleep_float_a: assert property (sleepActive |-> !dataOe) else $error("pins driven in sleep");
    write_mask_a: assert property (arrayLaneWrite != 4'h0 |-> !dataOe) else $error("pins driven in write");
    oe_float_a: assert property (output_enable_n |-> !dataOe) else $error("pins driven with enable high");
    read_drive_a: assert property (arrayRead && $past(arrayRead) && !output_enable_n |-> dataOe)
        else $error("read data not driven");
    suspend_read_a: assert property (suspRd_s |=> arrayRead && $stable(arrayAddr))
        else $error("suspended read moved");
    linear_step_a: assert property ((!sleep_request && !burstOrderSel)[*4] ##0 !sleepActive && arrayRead
        && noStb && !burst_advance_n && global_write_n && byte_write_enable_n
        |=> arrayRead && arrayAddr[1:0] == $past(arrayAddr[1:0]) + 2'h1) else $error("linear step wrong");
    suspend_write_a: assert property (awake_s ##0 arrayLaneWrite == 4'hF && noStb && burst_advance_n
        && !global_write_n |=> arrayLaneWrite == 4'hF && $stable(arrayAddr)) else $error("suspended write moved");
endmodule : psc_sram_decode_sva

bind psc_sram_decode psc_sram_decode_sva #(.ADDR_W(ADDR_W), .LANES(LANES)) i_sva
(
    .ref_clk, .rst_n, .dataOe, .sleepActive, .arrayRead, .primary_chip_enable_n, .depth_enable_high,
    .depth_enable_low_n, .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
    .global_write_n, .byte_write_enable_n, .output_enable_n, .sleep_request, .burstOrderSel,
    .addr, .arrayAddr, .dataIn, .parityIn, .arrayLaneWrite, .arrayWriteData
);

// ==== psc_array_model.sv ====
/* Behavioural storage array behind the decoder.
   Assumes lane strobes last one cycle and reads are combinational on the address. */
`timescale 1ns/1ps
module psc_array_model
(
    input  wire logic        ref_clk,
    input  wire logic [14:0] arrayAddr,
    input  wire logic [3:0]  arrayLaneWrite,
    input  wire logic [35:0] arrayWriteData,
    output logic      [35:0] arrayReadData
);
    logic [35:0] mem [0:32767];   // Word store; unwritten words read unknown on purpose
    assign arrayReadData = mem[arrayAddr];
    // Each strobed lane takes its byte and its parity bit, others stay put
    always @(posedge ref_clk)
        for (int i = 0; i < 4; i++)
            if (arrayLaneWrite[i])
            begin
                mem[arrayAddr][8*i+:8] <= arrayWriteData[8*i+:8];
                mem[arrayAddr][32+i] <= arrayWriteData[32+i];
            end
endmodule : psc_array_model

// ==== pipelined_burst_sram_cycle_decode_test.sv ====
/* Self-checking bench for psc_sram_decode with a storage array model.
   Assumes a 25 MHz clock and bus controls packed as {oe,ce1,processor_addr_strobe_n,controller_addr_strobe_n,adv,gw,bwe,sleep}. */
`timescale 1ns/1ps
module pipelined_burst_sram_cycle_decode_test
    import psc_pkg::*;
;
    localparam logic [7:0] IDLE = 8'b0110_1110;   // Deselect by controller strobe
    localparam logic [7:0] PRD  = 8'b0001_1110;   // Processor strobe read, output enabled
    localparam logic [7:0] SUSR = 8'b0011_1110;   // No strobe, hold address
    localparam logic [7:0] CONT = 8'b0011_0110;   // No strobe, advance
    localparam logic [7:0] QUIET = 8'b1111_1110;  // Nothing active, safe around sleep
    logic ref_clk = 0, rst_n = 0, depth_enable_high = 1, depth_enable_low_n = 0, burstOrderSel = 1;
    logic primary_chip_enable_n = 1, processor_addr_strobe_n = 1, controller_addr_strobe_n = 1;
    logic burst_advance_n = 1, global_write_n = 1, byte_write_enable_n = 1, output_enable_n = 1;
    logic sleep_request = 0, dataOe, arrayRead, sleepActive;
    logic [14:0] addr = '0, arrayAddr, a;
    logic [31:0] dataIn = '0, dataOut;
    logic [3:0]  parityIn = '0, byte_lane_write_n = '1, parityOut, arrayLaneWrite;
    logic [35:0] arrayWriteData, arrayReadData, wd, sw;
    logic [35:0] expMem [int];   // Expected contents by address
    int          checks = 0, n_fail = 0;
    always #20 ref_clk = ~ref_clk;
    psc_sram_decode i_dut (.ref_clk, .rst_n, .addr, .dataIn, .parityIn, .dataOut, .parityOut, .dataOe,
        .primary_chip_enable_n, .depth_enable_high, .depth_enable_low_n, .processor_addr_strobe_n,
        .controller_addr_strobe_n, .burst_advance_n, .global_write_n, .byte_write_enable_n,
        .byte_lane_write_n, .output_enable_n, .sleep_request, .burstOrderSel, .arrayAddr, .arrayRead,
        .arrayLaneWrite, .arrayWriteData, .arrayReadData, .sleepActive);
    psc_array_model i_mem (.ref_clk, .arrayAddr, .arrayLaneWrite, .arrayWriteData, .arrayReadData);

    // Lanes a write should strobe; global write wins, then byte enable
    function automatic logic [3:0] wl(logic g, logic b, logic [3:0] l);
        return !g ? 4'hF : (!b ? ~l : 4'h0);
    endfunction : wl
    // Merge new lanes into an old word
    function automatic logic [35:0] mrg(logic [35:0] o, logic [35:0] n, logic [3:0] l);
        for (int i = 0; i < 4; i++)
            if (l[i])
            begin
                o[8*i+:8] = n[8*i+:8];
                o[32+i] = n[32+i];
            end
        return o;
    endfunction : mrg
    // Low address bits of beat n of a burst from start s
    function automatic logic [1:0] bseq(logic [1:0] s, int n, bit lin);
        return lin ? 2'(s + 2'(n)) : (s ^ 2'(n));
    endfunction : bseq
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One bus cycle: new controls right after the edge, fresh random write data
    task automatic ctl(input logic [7:0] c, input logic [3:0] l, input logic [14:0] ad);
        @(posedge ref_clk);
        wd = {4'($urandom), 32'($urandom)};
        {output_enable_n, primary_chip_enable_n, processor_addr_strobe_n, controller_addr_strobe_n,
         burst_advance_n, global_write_n, byte_write_enable_n, sleep_request} <= c;
        byte_lane_write_n <= l;
        addr <= ad;
        {parityIn, dataIn} <= wd;
    endtask : ctl
    // Write by controller strobe, or by processor strobe then a held-address cycle
    task automatic wr(input logic [14:0] ad, input logic g, input logic b, input logic [3:0] l, input bit p);
        logic [35:0] w;
        logic [3:0]  e;
        e = wl(g, b, l);
        if (p)
        begin
            ctl(8'b1001_1000, 4'h0, ad);
            ctl({5'b11111, g, b, 1'b0}, l, 15'h7FFF);
            w = wd;
            #1 chk("procFirstRead", 1, arrayRead);
            chk("procFirstLanes", 0, arrayLaneWrite);
        end
        else
        begin
            ctl({5'b10101, g, b, 1'b0}, l, ad);
            w = wd;
        end
        ctl(IDLE, 4'h0, ad);
        #1 chk("laneWrite", e, arrayLaneWrite);
        chk("writeAddr", ad, arrayAddr);
        if (e != 4'h0)
            chk("writeData", w, arrayWriteData);
        expMem[ad] = mrg(expMem.exists(ad) ? expMem[ad] : 36'h0, w, e);
    endtask : wr
    // Read with one suspend cycle, then check data and the asynchronous enable
    task automatic rd(input logic [14:0] ad);
        ctl(PRD, 4'h0, ad);
        ctl(SUSR, 4'h0, 15'h7FFF);
        ctl(IDLE, 4'h0, ad);
        #1 chk("readData", expMem[ad], {parityOut, dataOut});
        chk("readDrive", 1, dataOe);
        output_enable_n <= 1'b1;
        #1 chk("oeAsync", 0, dataOe);
    endtask : rd
    // Four-beat burst in the chosen order
    task automatic bst(input logic [14:0] ad, input bit lin);
        burstOrderSel <= !lin;
        repeat (4) ctl(IDLE, 4'h0, ad);
        ctl(PRD, 4'h0, ad);
        for (int n = 1; n < 4; n++)
        begin
            ctl(CONT, 4'h0, 15'h7FFF);
            #1 chk("burstAddr", {ad[14:2], bseq(ad[1:0], n - 1, lin)}, arrayAddr);
            if (n > 1)
                chk("burstData", expMem[{ad[14:2], bseq(ad[1:0], n - 2, lin)}],
                    {parityOut, dataOut});
        end
        ctl(IDLE, 4'h0, ad);
        #1 chk("burstAddr", {ad[14:2], bseq(ad[1:0], 3, lin)}, arrayAddr);
        chk("burstData", expMem[{ad[14:2], bseq(ad[1:0], 2, lin)}], {parityOut, dataOut});
    endtask : bst
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // Hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        $display("watchdog expired");
        summarize();
    end
    // Main sequence
    initial
    begin
        void'($urandom(93));
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            wr(15'h10 + 15'(i), 1'b0, 1'b1, 4'h0, i[0]);
        $display("test fill done");
        wr(15'h11, 1'b1, 1'b0, 4'hF, 1'b0);
        wr(15'h12, 1'b1, 1'b1, 4'h0, 1'b1);
        repeat (16)
        begin
            a = 15'h10 + 15'($urandom_range(7));
            wr(a, 1'($urandom_range(3) != 0), 1'($urandom), 4'($urandom), 1'($urandom));
            rd(a);
        end
        $display("test random write read done");
        for (int i = 0; i < 8; i++)
            bst(15'h10 + 15'($urandom_range(7)), i[0]);
        $display("test burst order done");
        // Controller write, then a suspended write, then a write at the next beat
        ctl(8'b1010_1010, 4'hF, 15'h14);
        ctl(8'b1011_1010, 4'hF, 15'h7FFF);
        sw = wd;
        ctl(8'b1011_0010, 4'hF, 15'h7FFF);
        #1 chk("suspLanes", 4'hF, arrayLaneWrite);
        chk("suspAddr", 15'h14, arrayAddr);
        chk("suspData", sw, arrayWriteData);
        expMem[15'h14] = sw;
        sw = wd;
        ctl(IDLE, 4'h0, 15'h14);
        #1 chk("contAddr", 15'h15, arrayAddr);
        chk("contData", sw, arrayWriteData);
        expMem[15'h15] = sw;
        $display("test write burst done");
        depth_enable_high <= 1'b0;
        ctl(PRD, 4'h0, 15'h10);
        ctl(IDLE, 4'h0, 15'h10);
        #1 chk("deselRead", 0, arrayRead);
        depth_enable_high <= 1'b1;
        $display("test deselect done");
        ctl(QUIET, 4'h0, 15'h10);
        repeat (4) ctl(QUIET | 8'h01, 4'h0, 15'h10);
        ctl(PRD | 8'h01, 4'h0, 15'h10);
        ctl(QUIET | 8'h01, 4'h0, 15'h10);
        #1 chk("sleeping", 1, sleepActive);
        chk("sleepRead", 0, arrayRead);
        repeat (7) ctl(QUIET, 4'h0, 15'h10);
        #1 chk("awake", 0, sleepActive);
        rd(15'h13);
        $display("test sleep done");
        summarize();
    end
endmodule : pipelined_burst_sram_cycle_decode_test
